// *** verilog/cas_core_select.sv ***
// Purpose: address hold and drive/divert selection for odd and even core units
// Assumes: one load command at a time; drive windows come from storage sequencing
// Notes: no sense, inhibit or sequence timing here
`timescale 1ns/100ps
`include "cas_params.svh"
// Operation
// - accept a 15-bit word address, 32768 locations, octal 00000 to 77777.
// - lowest address bit routes the reference to odd or even unit.
// - other 14 bits load into the chosen unit's hold register.
// - two bits above unit bit are quadrant; low three bits pick octant.
// - next six bits pick vertical selection, top six horizontal.
// - vertical driver code is bits 1,8,7, bit 1 most significant.
// - horizontal driver code is bits 2,14,13, bit 2 most significant.
// - hold register has 14 stages and keeps address through a reference.
// - accumulator and program loads force every stage, no prior clear.
// - vertical driver from stages 01,07,08; horizontal from 02,13,14.
// - driver select ANDs read or write term with its drive window.
// - each translator selects exactly one of eight drivers.
// - one horizontal and one vertical driver narrow to 256 locations.
// - sixteen wires share a driver, eight sections per direction.
// - one horizontal and one vertical diverter complete the current path.
// - vertical diverter cycles per 8 addresses, driver per 128.
// - dummy load on when idle, off 6.2 us per reference.
// - each unit holds 16384 words of 48 bits, read all at once.
// - even unit uses first hold register, odd unit the second.
// - diverter translators use stages 03-06 and 09-12, one of sixteen.
module cas_core_select
   import cas_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic [`CAS_ADDR_W-1:0] operand_accumulator,
   input wire logic [`CAS_ADDR_W-1:0] program_address_source,
   input wire logic [`CAS_ADDR_W-1:0] buffer_channel_address,
   input wire logic load_from_acc,
   input wire logic load_from_prog,
   input wire logic load_from_buf,
   input wire logic read_drive,
   input wire logic write_drive,
   input wire logic dummy_drive,
   output logic unit_odd,
   output logic [`CAS_HOLD_W-1:0] even_unit_address_hold,
   output logic [`CAS_HOLD_W-1:0] odd_unit_address_hold,
   output logic [`CAS_DRV_N-1:0] even_vdrv_read,
   output logic [`CAS_DRV_N-1:0] even_vdrv_write,
   output logic [`CAS_DRV_N-1:0] even_hdrv_read,
   output logic [`CAS_DRV_N-1:0] even_hdrv_write,
   output logic [`CAS_DIV_N-1:0] even_vdiv_sel,
   output logic [`CAS_DIV_N-1:0] even_hdiv_sel,
   output logic [`CAS_DRV_N-1:0] odd_vdrv_read,
   output logic [`CAS_DRV_N-1:0] odd_vdrv_write,
   output logic [`CAS_DRV_N-1:0] odd_hdrv_read,
   output logic [`CAS_DRV_N-1:0] odd_hdrv_write,
   output logic [`CAS_DIV_N-1:0] odd_vdiv_sel,
   output logic [`CAS_DIV_N-1:0] odd_hdiv_sel,
   output logic dummy_load_sel
);
   // ====================================================
   // state
   typedef struct packed {
      cas_hold_t even_hold;
      cas_hold_t odd_hold;
      logic unit_odd;
      cas_dummy_t dummy;
      logic [`CAS_DUMMY_CNT_W-1:0] dummy_cnt;
      logic dummy_drive_prev;
   } cas_state_t;

   cas_state_t st_reg;
   cas_state_t st_next;
   logic [`CAS_ADDR_W-1:0] ld_addr;
   logic ld_any;
   logic drv_rd_win;
   logic drv_wr_win;

   // ====================================================
   // load and dummy-load sequencing
   always_comb
   begin
      st_next = st_reg;
      ld_any = load_from_acc | load_from_prog | load_from_buf;
      ld_addr = '0;
      priority case (1'b1)
         load_from_acc: ld_addr = operand_accumulator;
         load_from_prog: ld_addr = program_address_source;
         load_from_buf: ld_addr = buffer_channel_address;
         default: ld_addr = '0;
      endcase
      if (ld_any)
      begin
         // forced transfer: every stage written directly
         st_next.unit_odd = ld_addr[0];
         if (ld_addr[0])
            st_next.odd_hold = ld_addr[`CAS_ADDR_W-1:1];
         else
            st_next.even_hold = ld_addr[`CAS_ADDR_W-1:1];
      end
      // otherwise hold registers keep value
      st_next.dummy_drive_prev = dummy_drive;
      unique case (st_reg.dummy)
         cas_dummy_on:
            if (dummy_drive && !st_reg.dummy_drive_prev)
            begin
               st_next.dummy = cas_dummy_off;
               st_next.dummy_cnt = `CAS_DUMMY_CNT_W'(`CAS_DUMMY_OFF_CYC - 1);
            end
         cas_dummy_off:
            if (st_reg.dummy_cnt == '0)
               st_next.dummy = cas_dummy_on;
            else
               st_next.dummy_cnt = st_reg.dummy_cnt - 1'b1;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         st_reg.even_hold <= `CAS_HOLD_RST;
         st_reg.odd_hold <= `CAS_HOLD_RST;
         st_reg.unit_odd <= 1'b0;
         st_reg.dummy <= cas_dummy_on;
         st_reg.dummy_cnt <= '0;
         st_reg.dummy_drive_prev <= 1'b0;
      end
      else
         st_reg <= st_next;
   end

   assign unit_odd = st_reg.unit_odd;
   assign even_unit_address_hold = st_reg.even_hold;
   assign odd_unit_address_hold = st_reg.odd_hold;
   assign dummy_load_sel = (st_reg.dummy == cas_dummy_on);
   // windows reach only the unit under reference
   assign drv_rd_win = read_drive;
   assign drv_wr_win = write_drive;

   // ====================================================
   // translators per unit
   logic even_rd;
   logic even_wr;
   logic odd_rd;
   logic odd_wr;
   assign even_rd = drv_rd_win & ~st_reg.unit_odd;
   assign even_wr = drv_wr_win & ~st_reg.unit_odd;
   assign odd_rd = drv_rd_win & st_reg.unit_odd;
   assign odd_wr = drv_wr_win & st_reg.unit_odd;

   // sixteen wires per driver, eight sections per direction
   cas_unit_decode u_even (
      .hold(st_reg.even_hold),
      .read_drive(even_rd),
      .write_drive(even_wr),
      .vdrv_read(even_vdrv_read),
      .vdrv_write(even_vdrv_write),
      .hdrv_read(even_hdrv_read),
      .hdrv_write(even_hdrv_write),
      .vdiv_sel(even_vdiv_sel),
      .hdiv_sel(even_hdiv_sel)
   );

   cas_unit_decode u_odd (
      .hold(st_reg.odd_hold),
      .read_drive(odd_rd),
      .write_drive(odd_wr),
      .vdrv_read(odd_vdrv_read),
      .vdrv_write(odd_vdrv_write),
      .hdrv_read(odd_hdrv_read),
      .hdrv_write(odd_hdrv_write),
      .vdiv_sel(odd_vdiv_sel),
      .hdiv_sel(odd_hdiv_sel)
   );
   // one 48-bit word per location, 16384 per unit, in the plane stacks

   // ====================================================
   // checks
   property p_hold_keep;
      @(posedge mclk) disable iff (srst)
      !(load_from_acc || load_from_prog || load_from_buf) |=>
         $stable(even_unit_address_hold) && $stable(odd_unit_address_hold);
   endproperty
   a_hold_keep: assert property (p_hold_keep) else $error("hold changed without load");

   property p_even_load;
      @(posedge mclk) disable iff (srst)
      load_from_acc && !operand_accumulator[0] |=>
         even_unit_address_hold == $past(operand_accumulator[`CAS_ADDR_W-1:1]);
   endproperty
   a_even_load: assert property (p_even_load) else $error("even load wrong");

   property p_odd_load;
      @(posedge mclk) disable iff (srst)
      load_from_prog && program_address_source[0] |=>
         odd_unit_address_hold == $past(program_address_source[`CAS_ADDR_W-1:1]) && unit_odd;
   endproperty
   a_odd_load: assert property (p_odd_load) else $error("odd load wrong");

   property p_buf_other_kept;
      @(posedge mclk) disable iff (srst)
      load_from_buf && buffer_channel_address[0] |=> $stable(even_unit_address_hold);
   endproperty
   a_buf_other_kept: assert property (p_buf_other_kept) else $error("wrong unit loaded");

   property p_drv_window;
      @(posedge mclk) disable iff (srst)
      !read_drive |-> (even_vdrv_read == '0) && (odd_hdrv_read == '0);
   endproperty
   a_drv_window: assert property (p_drv_window) else $error("driver outside window");

   property p_drv_onehot;
      @(posedge mclk) disable iff (srst)
      write_drive && !unit_odd |-> $onehot(even_vdrv_write) && $onehot(even_hdrv_write);
   endproperty
   a_drv_onehot: assert property (p_drv_onehot) else $error("driver not one-hot");

   property p_vdrv_code;
      @(posedge mclk) disable iff (srst)
      read_drive && !unit_odd |-> even_vdrv_read[{even_unit_address_hold[`CAS_ST01],
         even_unit_address_hold[`CAS_ST08], even_unit_address_hold[`CAS_ST07]}];
   endproperty
   a_vdrv_code: assert property (p_vdrv_code) else $error("vertical driver code");

   property p_hdiv_code;
      @(posedge mclk) disable iff (srst)
      odd_hdiv_sel[odd_unit_address_hold[`CAS_ST12:`CAS_ST09]] && $onehot(odd_hdiv_sel);
   endproperty
   a_hdiv_code: assert property (p_hdiv_code) else $error("diverter code");

   sequence s_dummy_start;
      dummy_drive && dummy_load_sel && !$past(dummy_drive);
   endsequence
   property p_dummy_off;
      @(posedge mclk) disable iff (srst)
      s_dummy_start |=> !dummy_load_sel [*8];
   endproperty
   a_dummy_off: assert property (p_dummy_off) else $error("dummy load not off");

   property p_dummy_back;
      @(posedge mclk) disable iff (srst)
      $fell(dummy_load_sel) |-> ##[1:130] dummy_load_sel;
   endproperty
   a_dummy_back: assert property (p_dummy_back) else $error("dummy load stuck off");

   property p_odd_window;
      @(posedge mclk) disable iff (srst)
      !write_drive |-> (odd_vdrv_write == '0) && (even_hdrv_write == '0);
   endproperty
   a_odd_window: assert property (p_odd_window) else $error("write driver outside window");

   property p_odd_gate;
      @(posedge mclk) disable iff (srst)
      unit_odd |->
         (even_vdrv_read | even_vdrv_write | even_hdrv_read | even_hdrv_write) == '0;
   endproperty
   a_odd_gate: assert property (p_odd_gate) else $error("even drivers on");

   property p_even_gate;
      @(posedge mclk) disable iff (srst)
      !unit_odd |->
         (odd_vdrv_read | odd_vdrv_write | odd_hdrv_read | odd_hdrv_write) == '0;
   endproperty
   a_even_gate: assert property (p_even_gate) else $error("odd drivers on");

   property p_hdrv_code;
      @(posedge mclk) disable iff (srst)
      read_drive && unit_odd |-> odd_hdrv_read[{odd_unit_address_hold[`CAS_ST02],
         odd_unit_address_hold[`CAS_ST14], odd_unit_address_hold[`CAS_ST13]}];
   endproperty
   a_hdrv_code: assert property (p_hdrv_code) else $error("horizontal driver code");

   property p_wr_onehot;
      @(posedge mclk) disable iff (srst)
      write_drive && unit_odd |-> $onehot(odd_vdrv_write) && $onehot(odd_hdrv_write);
   endproperty
   a_wr_onehot: assert property (p_wr_onehot) else $error("write driver not one-hot");

   property p_vdiv_code;
      @(posedge mclk) disable iff (srst)
      even_vdiv_sel[even_unit_address_hold[`CAS_ST06:`CAS_ST03]] && $onehot(even_vdiv_sel);
   endproperty
   a_vdiv_code: assert property (p_vdiv_code) else $error("vertical diverter code");

   property p_acc_odd_load;
      @(posedge mclk) disable iff (srst)
      load_from_acc && operand_accumulator[0] |=>
         odd_unit_address_hold == $past(operand_accumulator[`CAS_ADDR_W-1:1]) && unit_odd;
   endproperty
   a_acc_odd_load: assert property (p_acc_odd_load) else $error("odd forced load");

   property p_prog_even_load;
      @(posedge mclk) disable iff (srst)
      load_from_prog && !load_from_acc && !program_address_source[0] |=>
         even_unit_address_hold == $past(program_address_source[`CAS_ADDR_W-1:1]) && !unit_odd;
   endproperty
   a_prog_even_load: assert property (p_prog_even_load) else $error("even forced load");

   property p_buf_load;
      @(posedge mclk) disable iff (srst)
      load_from_buf && !load_from_acc && !load_from_prog |=>
         (unit_odd ? odd_unit_address_hold : even_unit_address_hold) ==
         $past(buffer_channel_address[`CAS_ADDR_W-1:1]);
   endproperty
   a_buf_load: assert property (p_buf_load) else $error("buffer load wrong");

   property p_dummy_idle;
      @(posedge mclk) disable iff (srst)
      dummy_load_sel && !dummy_drive |=> dummy_load_sel;
   endproperty
   a_dummy_idle: assert property (p_dummy_idle) else $error("dummy load dropped idle");
endmodule : cas_core_select

// *** verilog/cas_params.svh ***
// Purpose: constants for the core address select and decode block
// Assumes: 15-bit word address, two units, 14-stage hold registers
// Notes: stage n of a hold register sits at bit n-1
`ifndef CAS_PARAMS_SVH
`define CAS_PARAMS_SVH
`define CAS_ADDR_W 15
`define CAS_HOLD_W 14
`define CAS_WORD_W 48
`define CAS_DRV_N 8
`define CAS_DIV_N 16
`define CAS_HOLD_RST 14'h0000
// stage positions within the hold register (stage n -> bit n-1)
`define CAS_ST01 0
`define CAS_ST02 1
`define CAS_ST03 2
`define CAS_ST06 5
`define CAS_ST07 6
`define CAS_ST08 7
`define CAS_ST09 8
`define CAS_ST12 11
`define CAS_ST13 12
`define CAS_ST14 13
// dummy load off time, in ns, and cycles at 50 ns (longest time: round down)
`define CAS_DUMMY_OFF_NS 6200
`define CAS_CLK_NS 50
`define CAS_DUMMY_OFF_CYC (`CAS_DUMMY_OFF_NS / `CAS_CLK_NS)
`define CAS_DUMMY_CNT_W 8
`endif

// *** verilog/cas_pkg.sv ***
// Purpose: types for the core address select and decode block
// Assumes: cas_params.svh holds the numbers
// Notes: none
`include "cas_params.svh"
package cas_pkg;
   typedef enum logic [1:0] {cas_ld_none, cas_ld_acc, cas_ld_prog, cas_ld_buf} cas_load_t;
   typedef enum logic {cas_dummy_on, cas_dummy_off} cas_dummy_t;
   typedef logic [`CAS_HOLD_W-1:0] cas_hold_t;
endpackage : cas_pkg

// *** verilog/cas_unit_decode.sv ***
// Purpose: per-unit driver and diverter translators
// Assumes: hold register value is stable during the drive windows
// Notes: purely combinational
`timescale 1ns/100ps
`include "cas_params.svh"
module cas_unit_decode
   import cas_pkg::*;
(
   input wire logic [`CAS_HOLD_W-1:0] hold,
   input wire logic read_drive,
   input wire logic write_drive,
   output logic [`CAS_DRV_N-1:0] vdrv_read,
   output logic [`CAS_DRV_N-1:0] vdrv_write,
   output logic [`CAS_DRV_N-1:0] hdrv_read,
   output logic [`CAS_DRV_N-1:0] hdrv_write,
   output logic [`CAS_DIV_N-1:0] vdiv_sel,
   output logic [`CAS_DIV_N-1:0] hdiv_sel
);
   // ====================================================
   // translators
   // one-hot of 3 bits: msb picks the upper four, win is the read/write term
   function automatic logic [`CAS_DRV_N-1:0] cas_drv(input logic [2:0] code, input logic win);
      logic [`CAS_DRV_N-1:0] v;
      v = '0;
      v[code] = win;
      return v;
   endfunction : cas_drv

   function automatic logic [`CAS_DIV_N-1:0] cas_div(input logic [3:0] code);
      logic [`CAS_DIV_N-1:0] v;
      v = '0;
      v[code] = 1'b1;
      return v;
   endfunction : cas_div

   logic [2:0] vcode;
   logic [2:0] hcode;
   always_comb
   begin
      // stage 01 most significant, then 08, 07
      vcode = {hold[`CAS_ST01], hold[`CAS_ST08], hold[`CAS_ST07]};
      // stage 02 most significant, then 14, 13
      hcode = {hold[`CAS_ST02], hold[`CAS_ST14], hold[`CAS_ST13]};
      vdrv_read = cas_drv(vcode, read_drive);
      vdrv_write = cas_drv(vcode, write_drive);
      hdrv_read = cas_drv(hcode, read_drive);
      hdrv_write = cas_drv(hcode, write_drive);
      vdiv_sel = cas_div(hold[`CAS_ST06:`CAS_ST03]);
      hdiv_sel = cas_div(hold[`CAS_ST12:`CAS_ST09]);
   end
endmodule : cas_unit_decode

// *** testbench/cas_path_model.sv ***
// Purpose: far side current path of one core unit
// Assumes: drive and divert selects come from the block
// Notes: path closes only with one of each kind selected
`timescale 1ns/100ps
`include "cas_params.svh"
module cas_path_model
   import cas_pkg::*;
(
   input wire logic [`CAS_DRV_N-1:0] vdrv,
   input wire logic [`CAS_DRV_N-1:0] hdrv,
   input wire logic [`CAS_DIV_N-1:0] vdiv,
   input wire logic [`CAS_DIV_N-1:0] hdiv,
   output logic path_ok,
   output logic [13:0] location
);
   // ==========================================
   // wire groups to one location
   always_comb
   begin
      path_ok = ($countones(vdrv) == 1) && ($countones(hdrv) == 1) &&
         ($countones(vdiv) == 1) && ($countones(hdiv) == 1);
      location = 14'h0000;
      for (int i = 0; i < 16; i++)
      begin
         if (i < 8 && vdrv[i]) location[6:4] = i[2:0];
         if (i < 8 && hdrv[i]) location[13:11] = i[2:0];
         if (vdiv[i]) location[3:0] = i[3:0];
         if (hdiv[i]) location[10:7] = i[3:0];
      end
   end
endmodule : cas_path_model

// *** testbench/cas_core_select_tb_top.sv ***
// Purpose: self-checking bench for the core address select block
// Assumes: inputs change at falling mclk
// Notes: path model sees the read selects of the active unit
`timescale 1ns/100ps
`include "cas_params.svh"
module cas_core_select_tb_top
   import cas_pkg::*;
;
   logic mclk, srst, la, lp, lb, rd, wr, dd, uo, dl, ok;
   logic [14:0] acc, prg, bfa;
   logic [13:0] eh, oh, loc;
   logic [7:0] evr, evw, ehr, ehw, ovr, ovw, ohr, ohw;
   logic [15:0] evd, ehd, ovd, ohd;
   int err_count, checks_done;
   cas_core_select dut (.mclk(mclk), .srst(srst), .operand_accumulator(acc),
      .program_address_source(prg), .buffer_channel_address(bfa), .load_from_acc(la),
      .load_from_prog(lp), .load_from_buf(lb), .read_drive(rd), .write_drive(wr),
      .dummy_drive(dd), .unit_odd(uo), .even_unit_address_hold(eh),
      .odd_unit_address_hold(oh), .even_vdrv_read(evr), .even_vdrv_write(evw),
      .even_hdrv_read(ehr), .even_hdrv_write(ehw), .even_vdiv_sel(evd),
      .even_hdiv_sel(ehd), .odd_vdrv_read(ovr), .odd_vdrv_write(ovw),
      .odd_hdrv_read(ohr), .odd_hdrv_write(ohw), .odd_vdiv_sel(ovd),
      .odd_hdiv_sel(ohd), .dummy_load_sel(dl));
   cas_path_model partner (.vdrv(evr | ovr), .hdrv(ehr | ohr), .vdiv(uo ? ovd : evd),
      .hdiv(uo ? ohd : ehd), .path_ok(ok), .location(loc));
   // ==========================================
   // clock and checks
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask : chk
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // ==========================================
   // one load; other sources carry the inverse
   task automatic ld(input int k, input logic [14:0] a);
      @(negedge mclk);
      acc = (k == 0) ? a : ~a;
      prg = (k == 1) ? a : ~a;
      bfa = (k == 2) ? a : ~a;
      la = (k == 0);
      lp = (k == 1);
      lb = (k == 2);
      @(negedge mclk);
      {la, lp, lb} = 3'h0;
   endtask : ld
   // judge active-unit outputs and two idle-unit drivers for loaded address a, per window
   task automatic chk_addr(input logic [14:0] a);
      logic [7:0] dv, dh;
      dv = 8'h01 << {a[1], a[8], a[7]};
      dh = 8'h01 << {a[2], a[14], a[13]};
      for (int w = 0; w < 4; w++)
      begin
         @(negedge mclk);
         {rd, wr} = w[1:0];
         #1;
         chk("unit", a[0], uo);
         chk("hold", a[14:1], a[0] ? oh : eh);
         chk("vrd", rd ? dv : 8'h00, a[0] ? ovr : evr);
         chk("vwr", wr ? dv : 8'h00, a[0] ? ovw : evw);
         chk("hrd", rd ? dh : 8'h00, a[0] ? ohr : ehr);
         chk("hwr", wr ? dh : 8'h00, a[0] ? ohw : ehw);
         chk("idle", 16'h0000, a[0] ? {evr, ehw} : {ovr, ohw});
         chk("vdiv", 16'h0001 << a[6:3], a[0] ? ovd : evd);
         chk("hdiv", 16'h0001 << a[12:9], a[0] ? ohd : ehd);
         if (rd)
         begin
            chk("path", 1'b1, ok);
            chk("loc", {a[2], a[14:13], a[12:9], a[1], a[8:7], a[6:3]}, loc);
         end
      end
      @(negedge mclk);
      {rd, wr} = 2'h0;
   endtask : chk_addr
   // ==========================================
   // scenarios
   task automatic t_reset;
      chk("rst", {14'h0000, 1'b0, 1'b1}, {eh, uo, dl});
      chk("rst_odd", 14'h0000, oh);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_loads;
      logic [14:0] t[4] = '{15'h7fff, 15'h0001, 15'h7ffe, 15'h4d2b};
      logic [14:0] a;
      for (int i = 0; i < 12; i++)
      begin
         if (i < 4) a = t[i];
         else
         begin
            a = 15'h0000;
            {a[1], a[8], a[7], a[14], a[13], a[2]} = {i[2:0], ~i[2:0]};
            {a[6:3], a[12:9], a[0]} = {i[3:0], ~i[3:0], i[0]};
         end
         ld(i % 3, a);
         chk_addr(a);
      end
      $display("t_loads done");
   endtask : t_loads
   task automatic t_b2b;
      @(negedge mclk);
      acc = 15'h2aaa;
      la = 1'b1;
      @(negedge mclk);
      {la, lb, bfa} = {2'h1, 15'h5555};
      @(negedge mclk);
      lb = 1'b0;
      chk("even", 14'h1555, eh);
      chk_addr(15'h5555);
      repeat (5) @(negedge mclk) {acc, prg, bfa} = {3{15'h1234}};
      chk("keep", 14'h1555, eh);
      chk_addr(15'h5555);
      $display("t_b2b done");
   endtask : t_b2b
   task automatic t_dummy;
      @(negedge mclk);
      dd = 1'b1;
      for (int i = 1; i <= `CAS_DUMMY_OFF_CYC; i++)
      begin
         @(negedge mclk);
         chk("dummy_off", 1'b0, dl);
         if (i == 60) dd = 1'b0;
         if (i == 61) dd = 1'b1;
      end
      @(negedge mclk);
      chk("dummy_on", 1'b1, dl);
      dd = 1'b0;
      $display("t_dummy done");
   endtask : t_dummy
   task automatic t_rst2;
      @(negedge mclk);
      dd = 1'b1;
      @(negedge mclk);
      chk("dummy_go", 1'b0, dl);
      {srst, dd} = 2'h2;
      @(negedge mclk);
      srst = 1'b0;
      chk("rst2", {14'h0000, 1'b0, 1'b1}, {eh, uo, dl});
      chk("rst2_odd", 14'h0000, oh);
      ld(1, 15'h0003);
      chk_addr(15'h0003);
      $display("t_rst2 done");
   endtask : t_rst2
   // ==========================================
   // main sequence and watchdog
   initial
   begin
      {la, lp, lb, rd, wr, dd, acc, prg, bfa} = '0;
      err_count = 0;
      checks_done = 0;
      srst = 1'b1;
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      t_reset;
      t_loads;
      t_b2b;
      t_dummy;
      t_rst2;
      give_verdict;
   end
   initial
   begin
      repeat (2000) @(posedge mclk);
      err_count++;
      give_verdict;
   end
endmodule : cas_core_select_tb_top
